// File: core/mode_regs.sv
// mode register bank: answers mode register write and read commands for
// the device information, feature one, set point, row hammer, repair,
// test, calibration pattern and activation decrement registers.
// assumes commands arrive decoded and on the command clock.
//
// Notes on behaviour
// - reserved bits always read back as zero.
// - reads of write-only or reserved registers give undefined data.
// - writes to read-only registers change nothing.
// - info register 00h: read-only, zq status 4:3, capabilities 2:0.
// - info bit 0: 0 both refresh modes, 1 modified mode only.
// - info bit 1: 0 normal latency, 1 byte-mode latency.
// - info bit 2: 0 targeted row refresh, 1 refresh management.
// - zq status codes: 00 none, 01 ground/float, 10 short, 11 pass.
// - zq status valid after start, latch and latch wait complete.
// - zq status is lost on reset.
// - assembly error: factory trim, later zq calibrations ignored.
// - grounded zq pin reports 01b.
// - feature register 01h field layout: bl, preambles, recovery, postamble.
// - burst length: 00 sixteen, 01 thirty-two, 10 on the fly, 11 reserved.
// - writes hit the write set point copy; operation uses the active copy.
`timescale 1ns/1ps
module mode_regs #(
  parameter bit         CAP_MODIFIED_REFRESH_ONLY = 1'b0,
  parameter bit         CAP_BYTE_MODE_LATENCY     = 1'b0,
  parameter bit         CAP_REFRESH_MANAGEMENT    = 1'b0,
  parameter bit         ZQ_SELFTEST_SUPPORTED     = 1'b1,
  parameter logic [7:0] RFM_STATUS_VALUE          = 8'h00,
  parameter logic [7:0] REPAIR_RESOURCES_VALUE    = 8'h00
) (
  // clock, reset, enable
  input  wire logic                  I_CLOCK,
  input  wire logic                  I_RST,
  input  wire logic                  I_CE,
  // mode register command
  input  wire mrs_pkg::mr_cmd_t      I_CMD,
  // zq calibration progress and pin condition
  input  wire logic                  I_ZQ_START_DONE,
  input  wire logic                  I_ZQ_LATCH_DONE,
  input  wire logic                  I_ZQ_PIN_GROUNDED,
  input  wire logic                  I_ZQ_PIN_SHORTED,
  // read answer
  output logic                       O_RD_VALID,
  output logic [7:0]                 O_RD_DATA,
  // operating configuration
  output mrs_pkg::feature_one_t      O_ACTIVE_FEATURE,
  output logic                       O_WRITE_SET_POINT,
  output logic                       O_OPERATING_SET_POINT,
  output logic [7:0]                 O_ROW_HAMMER_CTRL,
  output logic [1:0]                 O_ACT_DECREMENT,
  output logic [7:0]                 O_CAL_PATTERN_A,
  output logic [7:0]                 O_CAL_PATTERN_B,
  // zq fallback
  output logic                       O_ZQ_FACTORY_TRIM
);

  // ---------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------
  logic [7:0]                 feature_ff [2]; // one copy per set point
  logic                       wr_sp_ff;
  logic                       op_sp_ff;
  logic [7:0]                 row_hammer_ff;
  logic [7:0]                 decrement_ff;
  logic [7:0]                 pattern_a_ff;
  logic [7:0]                 pattern_b_ff;
  logic [1:0]                 zq_field;
  logic                       zq_error;
  logic [7:0]                 nxt_rd_data;
  logic [7:0]                 device_info;
  logic                       wr_en;
  mrs_pkg::feature_one_t      nxt_active;

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------

  // true when a write to this address may change stored state;
  // read-only, test and reserved addresses never match here
  function automatic logic writable(input logic [5:0] ma, input logic refresh_management);
    unique case (ma)
      mrs_pkg::MA_FEATURE_ONE,
      mrs_pkg::MA_SET_POINT_CTRL,
      mrs_pkg::MA_CAL_PATTERN_A,
      mrs_pkg::MA_ACT_DECREMENT,
      mrs_pkg::MA_CAL_PATTERN_B: writable = 1'b1;
      mrs_pkg::MA_ROW_HAMMER:    writable = !refresh_management;
      default:                   writable = 1'b0;
    endcase
  endfunction : writable

  // address match gated by a write command
  function automatic logic hit(input mrs_pkg::mr_cmd_t cmd,
                               input logic [5:0] ma);
    hit = cmd.mrw && (cmd.ma == ma);
  endfunction : hit

  // ---------------------------------------------------------------------
  // device information contents
  // ---------------------------------------------------------------------

  // upper three bits are reserved and tied low
  always_comb begin
    device_info = 8'h00;
    device_info[mrs_pkg::INFO_REFRESH_BIT] = CAP_MODIFIED_REFRESH_ONLY;
    device_info[mrs_pkg::INFO_LATENCY_BIT] = CAP_BYTE_MODE_LATENCY;
    device_info[mrs_pkg::INFO_RFM_BIT]     = CAP_REFRESH_MANAGEMENT;
    device_info[mrs_pkg::INFO_ZQ_LSB +: 2] = zq_field;
  end

  // one common write qualifier so read-only targets drop out early
  assign wr_en = I_CE && I_CMD.mrw && writable(I_CMD.ma, CAP_REFRESH_MANAGEMENT);

  // ---------------------------------------------------------------------
  // zq self-test
  // ---------------------------------------------------------------------
  zq_selftest #(
    .SUPPORTED      (ZQ_SELFTEST_SUPPORTED)
  ) u_zq (
    .clk            (I_CLOCK),
    .rst            (I_RST),
    .ce             (I_CE),
    .start_done     (I_ZQ_START_DONE),
    .latch_done     (I_ZQ_LATCH_DONE),
    .pin_grounded   (I_ZQ_PIN_GROUNDED),
    .pin_shorted    (I_ZQ_PIN_SHORTED),
    .zq_field       (zq_field),
    .assembly_error (zq_error)
  );

  // ---------------------------------------------------------------------
  // set point control
  // ---------------------------------------------------------------------

  // only the two set point bits are kept; the rest of this register
  // belongs to other logic and is not stored here
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      wr_sp_ff <= 1'b0;
      op_sp_ff <= 1'b0;
    end else if (wr_en && hit(I_CMD, mrs_pkg::MA_SET_POINT_CTRL)) begin
      wr_sp_ff <= I_CMD.op[mrs_pkg::SP_WR_BIT];
      op_sp_ff <= I_CMD.op[mrs_pkg::SP_OP_BIT];
    end
  end

  // ---------------------------------------------------------------------
  // feature one, duplicated per set point
  // ---------------------------------------------------------------------

  // a write lands only in the copy picked by the write set point; the
  // inactive copy may be preloaded before a frequency switch
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      feature_ff[0] <= mrs_pkg::RST_FEATURE_ONE;
      feature_ff[1] <= mrs_pkg::RST_FEATURE_ONE;
    end else if (wr_en && hit(I_CMD, mrs_pkg::MA_FEATURE_ONE)) begin
      feature_ff[wr_sp_ff] <= I_CMD.op;
    end
  end

  // operation follows the active copy only; layout is fixed by the
  // packed carrier, so bits map straight across
  assign nxt_active = mrs_pkg::feature_one_t'(feature_ff[op_sp_ff]);

  // ---------------------------------------------------------------------
  // row hammer control
  // ---------------------------------------------------------------------

  // stored only while the part runs targeted row refresh
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      row_hammer_ff <= mrs_pkg::RST_ROW_HAMMER;
    end else if (wr_en && hit(I_CMD, mrs_pkg::MA_ROW_HAMMER)) begin
      row_hammer_ff <= I_CMD.op;
    end
  end

  // ---------------------------------------------------------------------
  // activation decrement
  // ---------------------------------------------------------------------

  // reserved upper bits are never stored, so they cannot read back
  // non-zero even if a controller breaks the zero-fill convention
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      decrement_ff <= mrs_pkg::RST_DECREMENT;
    end else if (wr_en && hit(I_CMD, mrs_pkg::MA_ACT_DECREMENT)) begin
      decrement_ff <= I_CMD.op & mrs_pkg::DECREMENT_MASK;
    end
  end

  // ---------------------------------------------------------------------
  // calibration patterns
  // ---------------------------------------------------------------------

  // write-only pattern bytes handed to the training logic
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      pattern_a_ff <= mrs_pkg::RST_CAL_PATTERN;
      pattern_b_ff <= mrs_pkg::RST_CAL_PATTERN;
    end else if (wr_en) begin
      if (hit(I_CMD, mrs_pkg::MA_CAL_PATTERN_A)) begin
        pattern_a_ff <= I_CMD.op;
      end
      if (hit(I_CMD, mrs_pkg::MA_CAL_PATTERN_B)) begin
        pattern_b_ff <= I_CMD.op;
      end
    end
  end

  // ---------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------

  // write-only and reserved addresses answer a fixed filler; callers
  // must not depend on it, the zero keeps the answer deterministic
  always_comb begin
    nxt_rd_data = mrs_pkg::UNDEFINED_READ;
    unique case (I_CMD.ma)
      mrs_pkg::MA_DEVICE_INFO: begin
        nxt_rd_data = device_info;
      end
      mrs_pkg::MA_ROW_HAMMER: begin
        // with refresh management the status view is read-only and fixed by RFM_STATUS_VALUE; otherwise the stored control reads back
        nxt_rd_data = CAP_REFRESH_MANAGEMENT ? RFM_STATUS_VALUE : row_hammer_ff;
      end
      mrs_pkg::MA_REPAIR_RES: begin
        nxt_rd_data = REPAIR_RESOURCES_VALUE;
      end
      mrs_pkg::MA_ACT_DECREMENT: begin
        nxt_rd_data = decrement_ff & mrs_pkg::DECREMENT_MASK;
      end
      default: begin
        nxt_rd_data = mrs_pkg::UNDEFINED_READ;
      end
    endcase
  end

  // answer one cycle after the read command; a write and a read in the
  // same cycle is not expected, the read then sees the old contents
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_RD_VALID <= 1'b0;
      O_RD_DATA  <= mrs_pkg::RST_READ_DATA;
    end else if (I_CE) begin
      O_RD_VALID <= I_CMD.mrr;
      if (I_CMD.mrr) begin
        O_RD_DATA <= nxt_rd_data;
      end
    end
  end

  // ---------------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------------

  // outputs trail the stored state by one cycle so every port comes
  // straight from a flop; a set point switch takes effect one cycle late
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_ACTIVE_FEATURE      <= mrs_pkg::feature_one_t'(mrs_pkg::RST_FEATURE_ONE);
      O_WRITE_SET_POINT     <= 1'b0;
      O_OPERATING_SET_POINT <= 1'b0;
      O_ROW_HAMMER_CTRL     <= mrs_pkg::RST_ROW_HAMMER;
      O_ACT_DECREMENT       <= 2'h0;
      O_CAL_PATTERN_A       <= mrs_pkg::RST_CAL_PATTERN;
      O_CAL_PATTERN_B       <= mrs_pkg::RST_CAL_PATTERN;
      O_ZQ_FACTORY_TRIM     <= 1'b0;
    end else if (I_CE) begin
      O_ACTIVE_FEATURE      <= nxt_active;
      O_WRITE_SET_POINT     <= wr_sp_ff;
      O_OPERATING_SET_POINT <= op_sp_ff;
      O_ROW_HAMMER_CTRL     <= CAP_REFRESH_MANAGEMENT ? 8'h00 : row_hammer_ff;
      O_ACT_DECREMENT       <= decrement_ff[1:0];
      O_CAL_PATTERN_A       <= pattern_a_ff;
      O_CAL_PATTERN_B       <= pattern_b_ff;
      O_ZQ_FACTORY_TRIM     <= zq_error;
    end
  end

endmodule : mode_regs

// File: core/mrs_pkg.sv
// mode register set package: addresses, field layouts, reset values,
// encodings and timing counts shared by the register bank and zq logic.
// assumes a 200 MHz command clock; nothing else is imported.
package mrs_pkg;

  // ----
  // mode register addresses
  // ----
  localparam logic [5:0] MA_DEVICE_INFO    = 6'h00;
  localparam logic [5:0] MA_FEATURE_ONE    = 6'h01;
  localparam logic [5:0] MA_SET_POINT_CTRL = 6'h0d;
  localparam logic [5:0] MA_ROW_HAMMER     = 6'h18;
  localparam logic [5:0] MA_REPAIR_RES     = 6'h19;
  localparam logic [5:0] MA_TEST_RSVD_A    = 6'h1e;
  localparam logic [5:0] MA_CAL_PATTERN_A  = 6'h20;
  localparam logic [5:0] MA_ACT_DECREMENT  = 6'h24;
  localparam logic [5:0] MA_TEST_RSVD_B    = 6'h27;
  localparam logic [5:0] MA_CAL_PATTERN_B  = 6'h28;

  // ----
  // field positions
  // ----
  localparam int unsigned INFO_REFRESH_BIT = 0;
  localparam int unsigned INFO_LATENCY_BIT = 1;
  localparam int unsigned INFO_RFM_BIT     = 2;
  localparam int unsigned INFO_ZQ_LSB      = 3;
  localparam int unsigned SP_WR_BIT        = 6;
  localparam int unsigned SP_OP_BIT        = 7;
  localparam logic [7:0]  DECREMENT_MASK   = 8'h03;

  // ----
  // reset values
  // ----
  localparam logic [7:0] RST_FEATURE_ONE = 8'h00;
  localparam logic [7:0] RST_ROW_HAMMER  = 8'h00;
  localparam logic [7:0] RST_DECREMENT   = 8'h00;
  localparam logic [7:0] RST_CAL_PATTERN = 8'h00;
  localparam logic [7:0] RST_READ_DATA   = 8'h00;
  localparam logic [7:0] UNDEFINED_READ  = 8'h00;

  // ----
  // encodings
  // ----
  localparam logic [1:0] ZQ_NOT_SUPPORTED = 2'h0;
  localparam logic [1:0] ZQ_GND_OR_FLOAT  = 2'h1;
  localparam logic [1:0] ZQ_SUPPLY_SHORT  = 2'h2;
  localparam logic [1:0] ZQ_PASSED        = 2'h3;
  localparam logic [1:0] BL_SIXTEEN       = 2'h0;
  localparam logic [1:0] BL_THIRTY_TWO    = 2'h1;
  localparam logic [1:0] BL_ON_THE_FLY    = 2'h2;

  // ----
  // timing
  // ----
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned ZQLAT_NS      = 30;
  localparam int unsigned ZQLAT_CYCLES  =
    (ZQLAT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----
  // carriers
  // ----
  typedef struct packed {
    logic       mrw;
    logic       mrr;
    logic [5:0] ma;
    logic [7:0] op;
  } mr_cmd_t;

  typedef struct packed {
    logic       rd_postamble_long;
    logic [2:0] autoprecharge_write_recovery;
    logic       rd_preamble_toggle;
    logic       wr_preamble;
    logic [1:0] burst_length;
  } feature_one_t;

endpackage : mrs_pkg

// File: core/zq_selftest.sv
// zq pin self-test tracker: builds the two-bit status from a start /
// latch calibration sequence and the sampled pin condition.
// assumes calibration done pulses come from logic on the same clock.
`timescale 1ns/1ps
module zq_selftest #(
  parameter bit SUPPORTED = 1'b1
) (
  // clock, reset, enable
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // calibration progress pulses
  input  wire logic       start_done,
  input  wire logic       latch_done,
  // pin condition, asynchronous
  input  wire logic       pin_grounded,
  input  wire logic       pin_shorted,
  // result
  output logic      [1:0] zq_field,
  output logic            assembly_error
);

  logic [1:0] gnd_sync_ff;
  logic [1:0] vdd_sync_ff;
  logic       started_ff;
  logic [7:0] wait_ff;
  logic       waiting_ff;

  // two-stage synchronisers; logic reads only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gnd_sync_ff <= 2'h0;
      vdd_sync_ff <= 2'h0;
    end else if (ce) begin
      gnd_sync_ff <= {gnd_sync_ff[0], pin_grounded};
      vdd_sync_ff <= {vdd_sync_ff[0], pin_shorted};
    end
  end

  // sequence: start, then latch, then the latch wait runs out
  // once an assembly error is seen every further command is ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin // result discarded on reset
      started_ff     <= 1'b0;
      waiting_ff     <= 1'b0;
      wait_ff        <= 8'h00;
      zq_field       <= mrs_pkg::ZQ_NOT_SUPPORTED;
      assembly_error <= 1'b0;
    end else if (ce && SUPPORTED && !assembly_error) begin
      if (start_done) begin
        started_ff <= 1'b1;
      end
      if (latch_done && started_ff) begin
        waiting_ff <= 1'b1;
        wait_ff    <= 8'(mrs_pkg::ZQLAT_CYCLES - 1);
      end else if (waiting_ff) begin
        if (wait_ff == 8'h00) begin // latch wait elapsed
          waiting_ff <= 1'b0;
          started_ff <= 1'b0;
          if (gnd_sync_ff[1]) begin // grounded pin reports 01b
            zq_field       <= mrs_pkg::ZQ_GND_OR_FLOAT;
            assembly_error <= 1'b1;
          end else if (vdd_sync_ff[1]) begin
            zq_field       <= mrs_pkg::ZQ_SUPPLY_SHORT;
            assembly_error <= 1'b1;
          end else begin
            zq_field <= mrs_pkg::ZQ_PASSED;
          end
        end else begin
          wait_ff <= wait_ff - 8'h01;
        end
      end
    end
  end

endmodule : zq_selftest

// File: dv/mode_regs_asserts.sv
// checker for the mode register bank: read strobe, info layout, set
// point copies and zq fallback. sees only the bank's top-level ports.
`timescale 1ns/1ps
module mode_regs_asserts #(
  parameter bit CAP_MODIFIED_REFRESH_ONLY = 1'b0,
  parameter bit CAP_BYTE_MODE_LATENCY     = 1'b0,
  parameter bit CAP_REFRESH_MANAGEMENT    = 1'b0
) (
  // clock, reset, enable
  input wire logic                  I_CLOCK,
  input wire logic                  I_RST,
  input wire logic                  I_CE,
  // command and zq progress
  input wire mrs_pkg::mr_cmd_t      I_CMD,
  input wire logic                  I_ZQ_LATCH_DONE,
  input wire logic                  I_ZQ_PIN_GROUNDED,
  // observed outputs
  input wire logic                  O_RD_VALID,
  input wire logic [7:0]            O_RD_DATA,
  input wire mrs_pkg::feature_one_t O_ACTIVE_FEATURE,
  input wire logic                  O_WRITE_SET_POINT,
  input wire logic                  O_OPERATING_SET_POINT,
  input wire logic [7:0]            O_ROW_HAMMER_CTRL,
  input wire logic                  O_ZQ_FACTORY_TRIM
);
  // ----
  // sequences
  // ----
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);
  sequence take_write(logic [5:0] a);
    I_CE && I_CMD.mrw && I_CMD.ma == a;
  endsequence
  sequence read_answer(logic [5:0] a);
    O_RD_VALID && $past(I_CMD.ma) == a;
  endsequence
  // ----
  // properties
  // ----
  rd_strobe_a: assert property (I_CE && I_CMD.mrr |=> O_RD_VALID)
    else $error("read answer strobe missing");
  strobe_cause_a: assert property (O_RD_VALID |-> $past(I_CE && I_CMD.mrr))
    else $error("read strobe without a read");
  info_layout_a: assert property (read_answer(mrs_pkg::MA_DEVICE_INFO) |->
    O_RD_DATA[7:5] == 3'h0 && O_RD_DATA[2:0] == {CAP_REFRESH_MANAGEMENT,
    CAP_BYTE_MODE_LATENCY, CAP_MODIFIED_REFRESH_ONLY}) else $error("info register layout wrong");
  dec_upper_zero_a: assert property (read_answer(mrs_pkg::MA_ACT_DECREMENT) |->
    O_RD_DATA[7:2] == 6'h00) else $error("reserved decrement bits not zero");
  row_hammer_locked_a: assert property (CAP_REFRESH_MANAGEMENT |->
    O_ROW_HAMMER_CTRL == 8'h00) else $error("row hammer control changed while read-only");
  feature_follow_a: assert property (take_write(mrs_pkg::MA_FEATURE_ONE) ##0
    (O_WRITE_SET_POINT == O_OPERATING_SET_POINT && !$past(I_CMD.mrw && I_CMD.ma ==
    mrs_pkg::MA_SET_POINT_CTRL)) ##1 !(I_CMD.mrw && I_CMD.ma == mrs_pkg::MA_SET_POINT_CTRL)
    |=> O_ACTIVE_FEATURE == $past(I_CMD.op, 2)) else $error("active feature not written");
  set_point_a: assert property (take_write(mrs_pkg::MA_SET_POINT_CTRL) |=> ##1
    {O_OPERATING_SET_POINT, O_WRITE_SET_POINT} == $past(I_CMD.op[7:6], 2))
    else $error("set point selects not updated");
  trim_hold_a: assert property (O_ZQ_FACTORY_TRIM |=> O_ZQ_FACTORY_TRIM)
    else $error("factory trim dropped before reset");
  trim_rise_a: assert property (I_CE && I_ZQ_LATCH_DONE && I_ZQ_PIN_GROUNDED &&
    $past(I_ZQ_PIN_GROUNDED, 3) && !O_ZQ_FACTORY_TRIM |-> ##[7:10] O_ZQ_FACTORY_TRIM)
    else $error("grounded pin did not select factory trim");
endmodule : mode_regs_asserts

bind mode_regs mode_regs_asserts #(
  .CAP_MODIFIED_REFRESH_ONLY(CAP_MODIFIED_REFRESH_ONLY),
  .CAP_BYTE_MODE_LATENCY    (CAP_BYTE_MODE_LATENCY),
  .CAP_REFRESH_MANAGEMENT   (CAP_REFRESH_MANAGEMENT)
) u_asserts (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_CE(I_CE), .I_CMD(I_CMD),
  .I_ZQ_LATCH_DONE(I_ZQ_LATCH_DONE), .I_ZQ_PIN_GROUNDED(I_ZQ_PIN_GROUNDED),
  .O_RD_VALID(O_RD_VALID), .O_RD_DATA(O_RD_DATA), .O_ACTIVE_FEATURE(O_ACTIVE_FEATURE),
  .O_WRITE_SET_POINT(O_WRITE_SET_POINT), .O_OPERATING_SET_POINT(O_OPERATING_SET_POINT),
  .O_ROW_HAMMER_CTRL(O_ROW_HAMMER_CTRL), .O_ZQ_FACTORY_TRIM(O_ZQ_FACTORY_TRIM));

// File: dv/mr_ctrl_model.sv
// memory controller model: issues mode register commands and zq
// calibration progress pulses. assumes the bank samples on the rising edge.
`timescale 1ns/1ps
module mr_ctrl_model (
  // command clock
  input  wire logic        i_clock,
  // command and zq progress towards the bank
  output mrs_pkg::mr_cmd_t o_cmd,
  output logic             o_start_done,
  output logic             o_latch_done
);
  // idle until the bench asks; byte-mode latency is never selected here
  initial begin
    o_cmd = '0;
    o_start_done = 1'b0;
    o_latch_done = 1'b0;
  end
  // ----
  // command tasks, all launched at the falling edge
  // ----
  task automatic issue(input logic w, input logic [5:0] ma, input logic [7:0] op);
    @(negedge i_clock);
    o_cmd = '{mrw: w, mrr: !w, ma: ma, op: op};
    @(negedge i_clock);
    // released fields flip so a stale copy can never look valid
    o_cmd = '{mrw: 1'b0, mrr: 1'b0, ma: ~ma, op: ~op};
  endtask : issue
  task automatic write_reg(input logic [5:0] ma, input logic [7:0] op);
    logic rsvd;
    rsvd = ma inside {[6'h1a:6'h1d], 6'h1f, [6'h21:6'h23], 6'h25, 6'h26, [6'h29:6'h3f]};
    if (!rsvd) begin
      issue(1'b1, ma, op & ((ma == mrs_pkg::MA_ACT_DECREMENT) ? mrs_pkg::DECREMENT_MASK
        : 8'hff));
    end
  endtask : write_reg
  task automatic read_reg(input logic [5:0] ma);
    issue(1'b0, ma, 8'h00);
  endtask : read_reg
  // start completes before latch, as the calibration order demands
  task automatic zq_cal();
    @(negedge i_clock);
    o_start_done = 1'b1;
    @(negedge i_clock);
    o_start_done = 1'b0;
    o_latch_done = 1'b1;
    @(negedge i_clock);
    o_latch_done = 1'b0;
  endtask : zq_cal
endmodule : mr_ctrl_model

// File: dv/test_sdram_mode_register_set.sv
// self-checking bench for the mode register bank with a controller model.
// assumes mode_regs and mrs_pkg are compiled first; 200 MHz clock.
`timescale 1ns/1ps
`define CHK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", name, exp, got); end end
module test_sdram_mode_register_set;
  localparam logic [2:0] CAPS    = 3'b101;
  localparam logic [7:0] RFM_VAL = 8'h5a;
  localparam logic [7:0] REP_VAL = 8'h3c;
  logic                  clk         = 1'b0;
  logic                  rst         = 1'b1;
  logic                  ce          = 1'b1;
  logic                  pin_gnd     = 1'b0;
  logic                  pin_short   = 1'b0;
  mrs_pkg::mr_cmd_t      cmd;
  logic                  start_done;
  logic                  latch_done;
  logic                  rd_valid;
  logic [7:0]            rd_data;
  mrs_pkg::feature_one_t feature;
  logic                  wr_sp;
  logic                  op_sp;
  logic [7:0]            rh_ctrl;
  logic [1:0]            act_dec;
  logic [7:0]            cal_a;
  logic [7:0]            cal_b;
  logic                  trim;
  int                    fail_count  = 0;
  int                    checks_done = 0;
  // ----
  // clock, design and controller
  // ----
  always #2.5 clk = ~clk;
  mode_regs #(.CAP_MODIFIED_REFRESH_ONLY(CAPS[0]), .CAP_BYTE_MODE_LATENCY(CAPS[1]),
    .CAP_REFRESH_MANAGEMENT(CAPS[2]), .ZQ_SELFTEST_SUPPORTED(1'b1),
    .RFM_STATUS_VALUE(RFM_VAL), .REPAIR_RESOURCES_VALUE(REP_VAL)) uut (
    .I_CLOCK(clk), .I_RST(rst), .I_CE(ce), .I_CMD(cmd), .I_ZQ_START_DONE(start_done),
    .I_ZQ_LATCH_DONE(latch_done), .I_ZQ_PIN_GROUNDED(pin_gnd), .I_ZQ_PIN_SHORTED(pin_short),
    .O_RD_VALID(rd_valid), .O_RD_DATA(rd_data), .O_ACTIVE_FEATURE(feature),
    .O_WRITE_SET_POINT(wr_sp), .O_OPERATING_SET_POINT(op_sp), .O_ROW_HAMMER_CTRL(rh_ctrl),
    .O_ACT_DECREMENT(act_dec), .O_CAL_PATTERN_A(cal_a), .O_CAL_PATTERN_B(cal_b),
    .O_ZQ_FACTORY_TRIM(trim));
  mr_ctrl_model ctrl (.i_clock(clk), .o_cmd(cmd), .o_start_done(start_done),
    .o_latch_done(latch_done));
  // ----
  // shared steps
  // ----
  // judged at the release edge, while the one-cycle strobe stands
  task automatic rd_chk(input logic [5:0] ma, input logic [7:0] exp);
    ctrl.read_reg(ma);
    `CHK("read strobe", 1'b1, rd_valid)
    `CHK("read data", exp, rd_data)
  endtask : rd_chk
  task automatic wr(input logic [5:0] ma, input logic [7:0] op);
    ctrl.write_reg(ma, op);
    @(negedge clk);
  endtask : wr
  task automatic do_reset();
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
  endtask : do_reset
  // ----
  // scenarios
  // ----
  task automatic t_info();
    rd_chk(mrs_pkg::MA_DEVICE_INFO, {5'h00, CAPS});
    rd_chk(mrs_pkg::MA_REPAIR_RES, REP_VAL);
    rd_chk(mrs_pkg::MA_ROW_HAMMER, RFM_VAL);
  endtask : t_info
  // writes to read-only and test registers must leave everything alone
  task automatic t_read_only();
    logic [5:0] ro [5] = '{6'h00, 6'h19, 6'h18, 6'h1e, 6'h27};
    foreach (ro[i]) wr(ro[i], 8'hff);
    rd_chk(mrs_pkg::MA_DEVICE_INFO, {5'h00, CAPS});
    rd_chk(mrs_pkg::MA_REPAIR_RES, REP_VAL);
    rd_chk(mrs_pkg::MA_ROW_HAMMER, RFM_VAL);
    `CHK("row hammer ctrl", 8'h00, rh_ctrl)
    `CHK("feature", 8'h00, feature)
  endtask : t_read_only
  task automatic t_feature();
    logic [7:0] op;
    for (int bl = 0; bl < 4; bl++) begin
      op = {1'b1, 3'(bl + 3), 1'b1, 1'b0, 2'(bl)};
      wr(mrs_pkg::MA_FEATURE_ONE, op);
      `CHK("feature", op, feature)
      `CHK("burst length", 2'(bl), feature.burst_length)
    end
    rd_chk(mrs_pkg::MA_FEATURE_ONE, 8'h00);
  endtask : t_feature
  // the inactive copy takes writes without touching operation
  task automatic t_set_point();
    wr(mrs_pkg::MA_SET_POINT_CTRL, 8'h40);
    `CHK("write set point", 1'b1, wr_sp)
    wr(mrs_pkg::MA_FEATURE_ONE, 8'h24);
    `CHK("feature held", 8'heb, feature)
    wr(mrs_pkg::MA_SET_POINT_CTRL, 8'hc0);
    @(negedge clk);
    `CHK("operating set point", 1'b1, op_sp)
    `CHK("feature copy one", 8'h24, feature)
    wr(mrs_pkg::MA_SET_POINT_CTRL, 8'h00);
    @(negedge clk);
    `CHK("feature copy zero", 8'heb, feature)
  endtask : t_set_point
  task automatic t_misc();
    wr(mrs_pkg::MA_ACT_DECREMENT, 8'hff);
    `CHK("decrement", 2'h3, act_dec)
    rd_chk(mrs_pkg::MA_ACT_DECREMENT, 8'h03);
    wr(mrs_pkg::MA_CAL_PATTERN_A, 8'ha5);
    wr(mrs_pkg::MA_CAL_PATTERN_B, 8'h5a);
    `CHK("pattern a", 8'ha5, cal_a)
    `CHK("pattern b", 8'h5a, cal_b)
    rd_chk(mrs_pkg::MA_CAL_PATTERN_A, 8'h00);
    wr(6'h1a, 8'h77);
    rd_chk(6'h1a, 8'h00);
  endtask : t_misc
  // grounded, shorted and clean pins; an error latches until reset
  task automatic t_zq();
    logic [1:0] code [3] = '{2'h1, 2'h2, 2'h3};
    for (int k = 0; k < 3; k++) begin
      do_reset();
      pin_gnd = (k == 0);
      pin_short = (k == 1);
      repeat (3) @(negedge clk);
      rd_chk(mrs_pkg::MA_DEVICE_INFO, {5'h00, CAPS});
      ctrl.zq_cal();
      rd_chk(mrs_pkg::MA_DEVICE_INFO, {5'h00, CAPS});
      repeat (8) @(negedge clk);
      rd_chk(mrs_pkg::MA_DEVICE_INFO, {3'h0, code[k], CAPS});
      `CHK("factory trim", k < 2, trim)
      pin_gnd = 1'b0;
      pin_short = 1'b0;
      repeat (3) @(negedge clk);
      ctrl.zq_cal();
      repeat (10) @(negedge clk);
      rd_chk(mrs_pkg::MA_DEVICE_INFO, {3'h0, code[k], CAPS});
    end
    do_reset();
    rd_chk(mrs_pkg::MA_DEVICE_INFO, {5'h00, CAPS});
  endtask : t_zq
  // ----
  // verdict, main sequence and watchdog
  // ----
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  initial begin
    do_reset();
    t_info();
    t_read_only();
    t_feature();
    t_set_point();
    t_misc();
    t_zq();
    finish_test();
  end
  // the scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    finish_test();
  end
endmodule : test_sdram_mode_register_set
